//--- logic/ijl_exec.sv
// Constant load, interruptible jumps and signed halfword load unit.
`timescale 1ns/1ps
// Notes on behaviour
// - Constant load writes its 32-bit modifier, one cycle later.
// - Constant load ignores any guard and always writes.
// - Taken jump-on-false, nothing pending: loads all three counters.
// - Pending event: only destination counter set, exceptions first.
// - Jump-on-false with source bit 0 set continues sequentially.
// - Jump-on-true jumps when source bit 0 set, serving pending events.
// - Jump-on-true with source bit 0 clear continues sequentially.
// - Immediate jump takes its target from the 32-bit modifier.
// - False guard on a jump leaves all three counters untouched.
// - Jumps resolve after three delay slots and issue in slots 2 to 4.
// - Halfword load reads 16 bits at source address, sign-extends to 32.
// - Byte order flag picks which address gives the low byte.
// - Misaligned halfword load gives undefined data and no exception.
// - Halfword load in the I/O aperture gives undefined data.
// - True guard writes the destination and updates cacheable cache status.
// - False guard on the load: no write, no memory or cache activity.
// - Load has three cycles latency, opcode 6, slots 4 and 5.
module ijl_exec
  import ijl_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Operation issue.
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [2:0] op_slot,
  input wire logic op_guarded,
  input wire logic [DW-1:0] op_guard,
  input wire logic [DW-1:0] op_src1,
  input wire logic [DW-1:0] op_src2,
  input wire logic [DW-1:0] op_mod,
  input wire logic [RIW-1:0] op_dest,
  // Pending events.
  input wire logic exc_pending,
  input wire logic int_pending,
  // Data memory path.
  output logic dm_req,
  output logic [DW-1:0] dm_addr,
  input wire logic [7:0] dm_rbyte_lo,
  input wire logic [7:0] dm_rbyte_hi,
  input wire logic dm_cacheable,
  output logic dm_memory_mapped_io_aperture,
  output logic dc_upd,
  output logic [DW-1:0] dc_upd_addr,
  // Write-back.
  output logic imm_wb_valid,
  output logic [RIW-1:0] imm_wb_dest,
  output logic [DW-1:0] imm_wb_data,
  output logic ld_wb_valid,
  output logic [RIW-1:0] ld_wb_dest,
  output logic [DW-1:0] ld_wb_data,
  // Program flow.
  output logic pc_load,
  output logic [DW-1:0] pc_target,
  output logic svc_exc,
  output logic svc_int,
  output logic issue_err,
  output logic [DW-1:0] dest_pc,
  output logic [DW-1:0] restart_pc,
  // Avalon-MM slave.
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DW-1:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef struct packed {
    ijl_bus_t bus;
    logic waitreq;
    logic [DW-1:0] rdata;
    logic [DW-1:0] ctrl;
    logic [DW-1:0] destination_program_counter;
    logic [DW-1:0] restart_program_counter;
    logic [DW-1:0] pc;
    logic pc_load;
    logic [DW-1:0] pc_tgt;
    logic svc_exc;
    logic svc_int;
    logic issue_err;
    logic last_exc;
    logic last_int;
    logic imm_v;
    logic [RIW-1:0] imm_dst;
    logic [DW-1:0] imm_dat;
    logic br_v;
    logic [1:0] br_cnt;
    logic [DW-1:0] br_tgt;
    logic dm_req;
    logic [DW-1:0] dm_addr;
    logic memory_mapped_io_aperture;
    logic [RIW-1:0] l1_dst;
    logic l1_le;
    logic l2_v;
    logic [RIW-1:0] l2_dst;
    logic l2_le;
    logic [DW-1:0] l2_addr;
    logic ld_v;
    logic [RIW-1:0] ld_dst;
    logic [DW-1:0] ld_dat;
    logic dc_upd;
    logic [DW-1:0] dc_addr;
  } ijl_state_t;

  ijl_state_t s_reg;
  ijl_state_t s_next;
  logic [DW-1:0] rf_rdata;

  function automatic logic slot_ok(input logic [7:0] op,
                                   input logic [2:0] slot);
    logic [4:0] m;
    m = 5'h1f;
    case (op)
      OP_IMM: m = SLOTS_IMM;
      OP_JMPF, OP_JMPT, OP_JMPI: m = SLOTS_BR;
      OP_LD16: m = SLOTS_LD;
      default: m = 5'h1f;
    endcase
    if (slot < 3'h1 || slot > 3'h5) begin
      return 1'b0;
    end
    return m[slot - 3'h1];
  endfunction : slot_ok

  function automatic logic is_jump(input logic [7:0] op);
    return op == OP_JMPF || op == OP_JMPT || op == OP_JMPI;
  endfunction : is_jump

  function automatic logic in_rf(input logic [AW-1:0] a);
    return a[AW-1:9] == A_RF_TOP;
  endfunction : in_rf

  ijl_regfile u_rf (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .wa_en(s_reg.imm_v),
    .wa_addr(s_reg.imm_dst),
    .wa_data(s_reg.imm_dat),
    .wb_en(s_reg.ld_v),
    .wb_addr(s_reg.ld_dst),
    .wb_data(s_reg.ld_dat),
    .rd_addr(avs_address[8:2]),
    .rd_data(rf_rdata)
  );

  always_comb begin
    logic gd;
    logic take;
    logic [15:0] half;
    gd = 1'b0;
    take = 1'b0;
    half = 16'h0000;
    s_next = s_reg;
    s_next.pc_load = 1'b0;
    s_next.svc_exc = 1'b0;
    s_next.svc_int = 1'b0;
    s_next.issue_err = 1'b0;
    s_next.imm_v = 1'b0;
    s_next.dm_req = 1'b0;
    s_next.ld_v = 1'b0;
    s_next.dc_upd = 1'b0;
    gd = !op_guarded || op_guard[0];

    // Operation issue.
    if (op_valid) begin
      if (!slot_ok(op_code, op_slot)) begin
        s_next.issue_err = 1'b1;
      end else if (op_code == OP_IMM) begin
        s_next.imm_v = 1'b1;
        s_next.imm_dst = op_dest;
        s_next.imm_dat = op_mod;
      end else if (is_jump(op_code)) begin
        case (op_code)
          OP_JMPF: take = gd && !op_src1[0];
          OP_JMPT: take = gd && op_src1[0];
          default: take = gd;
        endcase
        if (s_reg.br_v) begin
          // A jump inside another jump's delay slots is refused.
          s_next.issue_err = 1'b1;
        end else if (take) begin
          s_next.br_v = 1'b1;
          s_next.br_cnt = BR_CNT_START;
          s_next.br_tgt = (op_code == OP_JMPI) ? op_mod : op_src2;
        end
      end else if (op_code == OP_LD16 && gd) begin
        // A false guard issues nothing at all to memory.
        s_next.dm_req = 1'b1;
        s_next.dm_addr = op_src1;
        s_next.memory_mapped_io_aperture = (op_src1 & MEMORY_MAPPED_IO_APERTURE_MASK) == MEMORY_MAPPED_IO_APERTURE_BASE;
        s_next.l1_dst = op_dest;
        s_next.l1_le = s_reg.ctrl[CTRL_LE_BIT];
      end
    end

    // Jump resolution after the delay slots.
    if (s_reg.br_v) begin
      if (s_reg.br_cnt != 2'h0) begin
        s_next.br_cnt = s_reg.br_cnt - 2'h1;
      end else begin
        s_next.br_v = 1'b0;
        s_next.destination_program_counter = s_reg.br_tgt;
        s_next.last_exc = exc_pending;
        s_next.last_int = !exc_pending && int_pending;
        if (exc_pending) begin
          s_next.svc_exc = 1'b1;
        end else if (int_pending) begin
          s_next.svc_int = 1'b1;
        end else begin
          s_next.pc = s_reg.br_tgt;
          s_next.restart_program_counter = s_reg.br_tgt;
          s_next.pc_load = 1'b1;
          s_next.pc_tgt = s_reg.br_tgt;
        end
      end
    end

    // Load data return, one cycle after the memory request.
    s_next.l2_v = s_reg.dm_req;
    s_next.l2_dst = s_reg.l1_dst;
    s_next.l2_le = s_reg.l1_le;
    s_next.l2_addr = s_reg.dm_addr;
    if (s_reg.l2_v) begin
      if (s_reg.l2_le) begin
        half = {dm_rbyte_hi, dm_rbyte_lo};
      end else begin
        half = {dm_rbyte_lo, dm_rbyte_hi};
      end
      s_next.ld_v = 1'b1;
      s_next.ld_dst = s_reg.l2_dst;
      s_next.ld_dat = {{16{half[15]}}, half};
      s_next.dc_upd = dm_cacheable;
      s_next.dc_addr = s_reg.l2_addr;
    end

    // Register bus: prepare, answer, then release.
    case (s_reg.bus)
      BUS_IDLE: begin
        s_next.waitreq = 1'b1;
        if (avs_read || avs_write) begin
          s_next.bus = BUS_PREP;
        end
      end
      BUS_PREP: begin
        s_next.bus = BUS_ACK;
        s_next.waitreq = 1'b0;
        s_next.rdata = '0;
        if (in_rf(avs_address)) begin
          s_next.rdata = rf_rdata;
        end else begin
          case (avs_address)
            A_CTRL: s_next.rdata = s_reg.ctrl;
            A_DPC: s_next.rdata = s_reg.destination_program_counter;
            A_SPC: s_next.rdata = s_reg.restart_program_counter;
            A_PC: s_next.rdata = s_reg.pc;
            A_STAT: begin
              s_next.rdata[ST_BR_BIT] = s_reg.br_v;
              s_next.rdata[ST_EXC_BIT] = s_reg.last_exc;
              s_next.rdata[ST_INT_BIT] = s_reg.last_int;
              s_next.rdata[ST_LD_BIT] = s_reg.dm_req || s_reg.l2_v;
              s_next.rdata[ST_MEMORY_MAPPED_IO_APERTURE_BIT] = s_reg.memory_mapped_io_aperture;
            end
            default: s_next.rdata = '0;
          endcase
        end
      end
      BUS_ACK: begin
        s_next.bus = BUS_IDLE;
        s_next.waitreq = 1'b1;
        if (avs_write && avs_address == A_CTRL) begin
          for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
              s_next.ctrl[b*8 +: 8] = avs_writedata[b*8 +: 8];
            end
          end
        end
      end
      default: begin
        s_next.bus = BUS_IDLE;
        s_next.waitreq = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.bus <= BUS_IDLE;
      s_reg.waitreq <= 1'b1;
      s_reg.ctrl <= CTRL_RST;
      s_reg.pc <= PC_RST;
      s_reg.restart_program_counter <= PC_RST;
      s_reg.destination_program_counter <= PC_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign dm_req = s_reg.dm_req;
  assign dm_addr = s_reg.dm_addr;
  assign dm_memory_mapped_io_aperture = s_reg.memory_mapped_io_aperture;
  assign dc_upd = s_reg.dc_upd;
  assign dc_upd_addr = s_reg.dc_addr;
  assign imm_wb_valid = s_reg.imm_v;
  assign imm_wb_dest = s_reg.imm_dst;
  assign imm_wb_data = s_reg.imm_dat;
  assign ld_wb_valid = s_reg.ld_v;
  assign ld_wb_dest = s_reg.ld_dst;
  assign ld_wb_data = s_reg.ld_dat;
  assign pc_load = s_reg.pc_load;
  assign pc_target = s_reg.pc_tgt;
  assign svc_exc = s_reg.svc_exc;
  assign svc_int = s_reg.svc_int;
  assign issue_err = s_reg.issue_err;
  assign dest_pc = s_reg.destination_program_counter;
  assign restart_pc = s_reg.restart_program_counter;
  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = s_reg.waitreq;
endmodule : ijl_exec

//--- logic/ijl_pkg.sv
// Shared constants for the interruptible jump and load execution block.
package ijl_pkg;
  localparam int DW = 32;
  localparam int RIW = 7;
  localparam int NREG = 128;
  localparam int AW = 12;

  localparam logic [7:0] OP_IMM = 8'hbf;
  localparam logic [7:0] OP_JMPF = 8'hb5;
  localparam logic [7:0] OP_JMPI = 8'hb3;
  localparam logic [7:0] OP_JMPT = 8'hb1;
  localparam logic [7:0] OP_LD16 = 8'h06;

  localparam int LAT_IMM = 1;
  localparam int LAT_LD = 3;
  localparam int BR_DELAY = 3;
  localparam logic [1:0] BR_CNT_START = 2'(BR_DELAY - 1);

  // Bit n-1 set means the operation may issue in slot n.
  localparam logic [4:0] SLOTS_IMM = 5'h1f;
  localparam logic [4:0] SLOTS_BR = 5'h0e;
  localparam logic [4:0] SLOTS_LD = 5'h18;

  localparam logic [AW-1:0] A_CTRL = 12'h000;
  localparam logic [AW-1:0] A_DPC = 12'h004;
  localparam logic [AW-1:0] A_SPC = 12'h008;
  localparam logic [AW-1:0] A_PC = 12'h00c;
  localparam logic [AW-1:0] A_STAT = 12'h010;
  localparam logic [2:0] A_RF_TOP = 3'h2;

  localparam int CTRL_LE_BIT = 0;
  localparam logic [DW-1:0] CTRL_RST = 32'h0000_0001;
  localparam logic [DW-1:0] PC_RST = 32'h0000_0000;

  localparam int ST_BR_BIT = 0;
  localparam int ST_EXC_BIT = 1;
  localparam int ST_INT_BIT = 2;
  localparam int ST_LD_BIT = 3;
  localparam int ST_MEMORY_MAPPED_IO_APERTURE_BIT = 4;

  localparam logic [DW-1:0] MEMORY_MAPPED_IO_APERTURE_BASE = 32'hf000_0000;
  localparam logic [DW-1:0] MEMORY_MAPPED_IO_APERTURE_MASK = 32'hfff0_0000;

  typedef enum logic [1:0] {BUS_IDLE, BUS_PREP, BUS_ACK} ijl_bus_t;
endpackage : ijl_pkg

//--- logic/ijl_regfile.sv
// Destination register file with two write ports and a registered read.
`timescale 1ns/1ps
module ijl_regfile
  import ijl_pkg::*;
(
  // Clock and control.
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // First write port.
  input wire logic wa_en,
  input wire logic [RIW-1:0] wa_addr,
  input wire logic [DW-1:0] wa_data,
  // Second write port, wins on the same address.
  input wire logic wb_en,
  input wire logic [RIW-1:0] wb_addr,
  input wire logic [DW-1:0] wb_data,
  // Read port.
  input wire logic [RIW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  typedef struct packed {
    logic [NREG-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } ijl_rf_t;

  ijl_rf_t s_reg;
  ijl_rf_t s_next;

  always_comb begin
    s_next = s_reg;
    if (wa_en) begin
      s_next.mem[wa_addr] = wa_data;
    end
    if (wb_en) begin
      s_next.mem[wb_addr] = wb_data;
    end
    s_next.rd = s_reg.mem[rd_addr];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rd;
endmodule : ijl_regfile

//--- sim/ijl_chk_asserts.sv
// Concurrent checks on the ports of the jump and load unit.
`timescale 1ns/1ps
module ijl_chk
  import ijl_pkg::*;
(
  // Clock, reset and issue.
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [2:0] op_slot,
  input wire logic op_guarded,
  input wire logic [DW-1:0] op_guard,
  input wire logic [DW-1:0] op_src1,
  input wire logic [DW-1:0] op_src2,
  input wire logic [DW-1:0] op_mod,
  input wire logic exc_pending,
  input wire logic int_pending,
  // Results.
  input wire logic dm_req,
  input wire logic [DW-1:0] dm_addr,
  input wire logic dm_cacheable,
  input wire logic dc_upd,
  input wire logic imm_wb_valid,
  input wire logic [DW-1:0] imm_wb_data,
  input wire logic ld_wb_valid,
  input wire logic pc_load,
  input wire logic [DW-1:0] pc_target,
  input wire logic svc_exc,
  input wire logic svc_int,
  input wire logic issue_err,
  input wire logic [DW-1:0] dest_pc
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic gok, isbr, ld, jt, jn, bad;
  logic [DW-1:0] tgt;
  assign gok = !op_guarded || op_guard[0];
  assign isbr = op_valid && op_code inside {OP_JMPF, OP_JMPI, OP_JMPT};
  assign ld = op_valid && op_code == OP_LD16 && op_slot inside {4, 5};
  assign jt = isbr && op_slot inside {[2:4]} && gok &&
    (op_code == OP_JMPI || op_src1[0] == (op_code == OP_JMPT));
  assign jn = isbr && op_slot inside {[2:4]} && !jt;
  assign bad = (isbr && !(op_slot inside {[2:4]})) ||
    (op_valid && op_code == OP_LD16 && !(op_slot inside {4, 5}));
  assign tgt = op_code == OP_JMPI ? op_mod : op_src2;
  property p_imm;
    op_valid && op_code == OP_IMM && op_slot inside {[1:5]} |=>
      imm_wb_valid && imm_wb_data == $past(op_mod);
  endproperty
  a_imm: assert property (p_imm) else $error("imm bad");
  property p_ldreq;
    ld && gok |=> dm_req && dm_addr == $past(op_src1);
  endproperty
  a_ldreq: assert property (p_ldreq) else $error("req bad");
  property p_ldlat;
    ld && gok |-> ##3 ld_wb_valid;
  endproperty
  a_ldlat: assert property (p_ldlat) else $error("lat bad");
  property p_cache;
    dm_req ##1 1'b1 |=> dc_upd == $past(dm_cacheable);
  endproperty
  a_cache: assert property (p_cache) else $error("cache bad");
  property p_jplain;
    jt ##3 (!exc_pending && !int_pending) |=> pc_load &&
      pc_target == $past(tgt, 4) && dest_pc == $past(tgt, 4);
  endproperty
  a_jplain: assert property (p_jplain) else $error("jmp bad");
  property p_jsvc;
    jt ##3 (exc_pending || int_pending) |=> !pc_load &&
      svc_exc == $past(exc_pending) && svc_int == !$past(exc_pending) &&
      dest_pc == $past(tgt, 4);
  endproperty
  a_jsvc: assert property (p_jsvc) else $error("svc bad");
  property p_jnot;
    jn |-> ##4 !(pc_load || svc_exc || svc_int);
  endproperty
  a_jnot: assert property (p_jnot) else $error("nojmp bad");
  property p_slot;
    bad |=> issue_err && !dm_req;
  endproperty
  a_slot: assert property (p_slot) else $error("slot bad");
endmodule : ijl_chk

bind ijl_exec ijl_chk u_chk (.*);

//--- sim/ijl_mem_model.sv
// Data memory answering halfword reads one cycle after a request.
`timescale 1ns/1ps
module ijl_mem_model
  import ijl_pkg::*;
(
  // Clock and request.
  input wire logic clk_sys,
  input wire logic dm_req,
  input wire logic [DW-1:0] dm_addr,
  // Answer.
  output logic [7:0] dm_rbyte_lo = 8'h00,
  output logic [7:0] dm_rbyte_hi = 8'h00,
  output logic dm_cacheable = 1'b0
);
  logic [7:0] mem [8] = '{8'h22, 8'h11, 8'h00, 8'h7f, 8'h84, 8'h33,
    8'h01, 8'hff};
  // Outside an answer the lines toggle, so stale data never looks valid.
  always @(posedge clk_sys) begin
    if (dm_req === 1'b1) begin
      dm_rbyte_lo <= mem[dm_addr[2:0]];
      dm_rbyte_hi <= mem[3'(dm_addr[2:0] + 3'h1)];
      dm_cacheable <= dm_addr[31:12] == 20'h0_0000;
    end else begin
      dm_rbyte_lo <= ~dm_rbyte_lo;
      dm_rbyte_hi <= ~dm_rbyte_hi;
      dm_cacheable <= ~dm_cacheable;
    end
  end
endmodule : ijl_mem_model

//--- sim/interruptible_jump_and_load_ops_tb.sv
// Self-checking bench for the jump and load unit.
`timescale 1ns/1ps
module interruptible_jump_and_load_ops_tb;
  import ijl_pkg::*;
  logic clk_sys = 0, srst = 1, ce = 1, op_valid = 0, op_guarded = 0;
  logic exc_pending = 0, int_pending = 0, avs_read = 0, avs_write = 0;
  logic [7:0] op_code = '0, dm_rbyte_lo, dm_rbyte_hi;
  logic [2:0] op_slot = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [RIW-1:0] op_dest = '0, imm_wb_dest, ld_wb_dest;
  logic [AW-1:0] avs_address = '0;
  logic [DW-1:0] op_guard = '0, op_src1 = '0, op_src2 = '0, op_mod = '0;
  logic [DW-1:0] avs_writedata = '0, avs_readdata, dm_addr, dc_upd_addr;
  logic [DW-1:0] imm_wb_data, ld_wb_data, pc_target, dest_pc, restart_pc;
  logic dm_req, dm_cacheable, dm_memory_mapped_io_aperture, dc_upd, imm_wb_valid, ld_wb_valid;
  logic pc_load, svc_exc, svc_int, issue_err, avs_waitrequest;
  logic [DW-1:0] rd, ed = '0, es = '0, ld_q[$], imm_q[$];
  logic [2:0] ev_q[$];
  logic [RIW-1:0] dq[$];
  logic [DW-1:0] dc_a = '0;
  int err_count = 0, n_checks = 0, n_dc = 0, n_req = 0, n_err = 0;
  logic [15:0] jc [8] = '{16'hb500, 16'hb510, 16'hb111, 16'hb100,
    16'hb363, 16'hb300, 16'hb540, 16'hb502};

  ijl_exec dut (.*);
  ijl_mem_model mem (.*);

  initial forever #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (ld_wb_valid === 1'b1) ld_q.push_back(ld_wb_data);
    if (imm_wb_valid === 1'b1) imm_q.push_back(imm_wb_data);
    if ((pc_load | svc_exc | svc_int) === 1'b1)
      ev_q.push_back({svc_exc, svc_int, pc_load});
    n_dc += int'(dc_upd === 1'b1);
    n_req += int'(dm_req === 1'b1);
    n_err += int'(issue_err === 1'b1);
    if (dc_upd === 1'b1) dc_a = dc_upd_addr;
    if (ld_wb_valid === 1'b1) dq.push_back(ld_wb_dest);
    if (imm_wb_valid === 1'b1) dq.push_back(imm_wb_dest);
  end

  task automatic close_out;
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [DW-1:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [AW-1:0] a,
      input logic [DW-1:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      close_out();
    end
  endtask : bus

  // Called just after an edge; the operation is taken at the next edge.
  task automatic issue(input logic [7:0] c, input logic [2:0] s,
      input logic [1:0] gv, input logic [DW-1:0] a, b);
    op_valid <= 1'b1;
    op_code <= c;
    op_slot <= s;
    op_guarded <= gv[1];
    op_guard <= DW'(gv[0]);
    op_src1 <= a;
    op_src2 <= b;
    op_mod <= b;
    op_dest <= b[RIW-1:0];
    @(posedge clk_sys);
  endtask : issue

  task automatic idle(input int n);
    op_valid <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : idle

  initial begin
    logic [15:0] c;
    logic [DW-1:0] t;
    logic tk;
    int k;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    chk("dest_pc", PC_RST, dest_pc);
    bus(0, A_CTRL, '0);
    chk("ctrl", CTRL_RST, rd);
    bus(0, 12'h0800, '0);
    chk("unmapped", '0, rd);
    for (int e = 1; e >= 0; e--) begin
      bus(1, A_CTRL, DW'(e));
      k = n_dc;
      issue(OP_LD16, 3'h4, 2'b11, 32'h0000_0d00, 32'h0000_0003);
      issue(OP_LD16, 3'h5, 2'b00, 32'h0000_0d04, 32'h0000_0004);
      issue(OP_LD16, 3'h4, 2'b00, 32'h0000_2d04, 32'h0000_0005);
      issue(OP_LD16, 3'h5, 2'b10, 32'h0000_0d00, 32'h0000_0004);
      issue(OP_LD16, 3'h4, 2'b00, 32'h0000_2d01, 32'h0000_0006);
      issue(OP_LD16, 3'h5, 2'b00, MEMORY_MAPPED_IO_APERTURE_BASE, 32'h0000_0007);
      idle(6);
      chk("loads", 5, ld_q.size());
      chk("ld a", e ? 32'h0000_1122 : 32'h0000_2211, ld_q[0]);
      chk("ld b", e ? 32'h0000_3384 : 32'hffff_8433, ld_q[1]);
      chk("ld c", ld_q[1], ld_q[2]);
      chk("cache", k + 2, n_dc);
      chk("requests", 10 - 5 * e, n_req);
      chk("no error", 0, n_err);
      bus(0, 12'h0410, '0);
      chk("dest kept", ld_q[1], rd);
      for (int j = 0; j < 5; j++)
        chk("ld dest", 3 + j, dq.pop_front());
      chk("memory_mapped_io_aperture", 1, dm_memory_mapped_io_aperture);
      chk("cache addr", 32'h0000_0d04, dc_a);
      bus(0, A_STAT, '0);
      chk("stat", 32'h0000_0001 << ST_MEMORY_MAPPED_IO_APERTURE_BIT, rd);
      ld_q.delete();
    end
    for (int s = 1; s <= 5; s++)
      issue(OP_IMM, 3'(s), 2'b10, '0, 32'hfffc_0000 + DW'(s));
    idle(3);
    chk("imm count", 5, imm_q.size());
    for (int s = 1; s <= 5; s++) begin
      chk("imm", 32'hfffc_0000 + DW'(s), imm_q.pop_front());
      chk("imm dest", s, dq.pop_front());
    end
    bus(0, 12'h0414, '0);
    chk("imm reg", 32'hfffc_0005, rd);
    // A low clock enable must stretch the write-back pulse over the freeze.
    issue(OP_IMM, 3'h1, 2'b00, '0, 32'h0000_0055);
    ce <= 1'b0;
    idle(3);
    ce <= 1'b1;
    idle(2);
    chk("ce hold", 4, imm_q.size());
    issue(OP_LD16, 3'h3, 2'b00, 32'h0000_0d00, 32'h0000_0001);
    issue(OP_JMPI, 3'h5, 2'b00, '0, 32'h0000_0400);
    issue(OP_JMPF, 3'h1, 2'b00, '0, 32'h0000_0400);
    idle(6);
    chk("slot err", 3, n_err);
    chk("slot req", 10, n_req);
    chk("slot jmp", 0, ev_q.size());
    for (int i = 0; i < 8; i++) begin
      c = jc[i];
      t = 32'h0000_8000 + DW'(i * 16);
      tk = (!c[6] || c[5]) &&
        (c[15:8] == OP_JMPI || c[4] == (c[15:8] == OP_JMPT));
      exc_pending <= c[1];
      int_pending <= c[0];
      issue(c[15:8], 3'(2 + i % 3), c[6:5], DW'(c[4]), t);
      idle(6);
      if (tk) ed = t;
      if (tk && c[1:0] == 2'b00) es = t;
      chk("events", DW'(tk), ev_q.size());
      if (tk)
        chk("kind", c[1] ? 3'h4 : c[0] ? 3'h2 : 3'h1, ev_q.pop_front());
      chk("dest_pc", ed, dest_pc);
      chk("restart_pc", es, restart_pc);
      chk("pc", es, pc_target);
    end
    exc_pending <= 1'b0;
    int_pending <= 1'b0;
    bus(1, A_DPC, 32'h1234_5678);
    bus(0, A_DPC, '0);
    chk("dpc reg", ed, rd);
    bus(0, A_SPC, '0);
    chk("spc reg", es, rd);
    bus(0, A_PC, '0);
    chk("pc reg", es, rd);
    close_out();
  end
endmodule : interruptible_jump_and_load_ops_tb
